// [pkg/fbm_pkg.sv]
/*
 Constants and the state type of the flash bank map and erase guard.
 Assumes a single system clock; nothing here holds logic.
*/
package fbm_pkg;

   // ************************************************************
   // Special function register addresses and fields
   // ************************************************************
   localparam logic [7:0] FBM_SFR_PGPTR = 8'hb7; // Erase page pointer, bits [7:1]
   localparam logic [7:0] FBM_SFR_LOCK = 8'hb2; // Holds the erase lock bit
   localparam int FBM_LOCK_BIT = 6;
   localparam int FBM_PGPTR_LSB = 1;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [1:0] FBM_BANK_RST = 2'h0;
   localparam logic [6:0] FBM_PGPTR_RST = 7'h00;
   localparam logic FBM_LOCK_RST = 1'b0;

   // ************************************************************
   // Address map
   // ************************************************************
   localparam int FBM_PROG_W = 16; // Processor program space
   localparam int FBM_PHYS_W = 17; // Physical flash, 128 KB
   localparam int FBM_PAGE_SHIFT = 10; // 1 KB pages
   localparam int FBM_PTR_SHIFT = 9; // Pointer bits sit at [15:9]
   localparam int FBM_CE_WORDS = 4096; // 16-bit words, 8 KB
   localparam int FBM_CE_WORD_W = 12;
   localparam int FBM_CE_PAGE_W = 7;
   localparam logic [6:0] FBM_PAGE_ZERO = 7'h00;
   localparam logic [16:0] FBM_PROT_TOP = 17'h1ffff;

   // Upper-bank select encodings
   localparam logic [1:0] FBM_BANK_ALIAS = 2'h0;
   localparam logic [1:0] FBM_BANK_8000 = 2'h1;
   localparam logic [1:0] FBM_BANK_10000 = 2'h2;
   localparam logic [1:0] FBM_BANK_18000 = 2'h3;

   // ************************************************************
   // Module state
   // ************************************************************
   typedef struct packed {
      logic [1:0] bank;
      logic [6:0] pgptr;
      logic lock;
      logic [7:0] sfr_rdata;
      logic [16:0] faddr;
      logic frd;
      logic fwr;
      logic [7:0] fwdata;
      logic fers;
      logic edone;
      logic erefused;
   } fbm_state_t;

endpackage : fbm_pkg

// [verilog/fbm_xlate.sv]
/*
 Program-space to physical flash translation through the bank select.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none

module fbm_xlate (
   // Program-space address and bank
   input wire logic [15:0] prog_addr,
   input wire logic [1:0] bank,
   // Physical flash address
   output logic [16:0] phys_addr
);

   // ************************************************************
   // Bank translation
   // ************************************************************

   // (R4) Lower window fixed
   // (R5) Upper window banked
   always_comb begin
      phys_addr = {1'b0, prog_addr};
      if (prog_addr[15]) begin
         unique case (bank)
            fbm_pkg::FBM_BANK_ALIAS: phys_addr = {2'h0, prog_addr[14:0]};
            fbm_pkg::FBM_BANK_8000: phys_addr = {2'h1, prog_addr[14:0]};
            fbm_pkg::FBM_BANK_10000: phys_addr = {2'h2, prog_addr[14:0]};
            fbm_pkg::FBM_BANK_18000: phys_addr = {2'h3, prog_addr[14:0]};
         endcase
      end
   end

endmodule : fbm_xlate

`default_nettype wire

// [verilog/fbm_guard.sv]
/*
 Flash bank map and erase guard: maps processor, compute engine and SPI
 accesses onto one flash port and filters page erase requests.
 Assumes requesters hold their request until granted, and that all
 inputs come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) Engine program spans at most 4096 words
// (R2) Engine program starts 1 KB aligned
// (R3) Engine page gives upper start bits
// (R4) Low 32 KB of program space fixed
// (R5) Bank select picks upper window base
// (R6) Erase pointer translated through bank select
// (R7) Engine page ignores bank select
// (R8) Lock blocks page 0 and engine pages
// (R9) SPI single-byte loads bank select
// (R10) Processor, engine read; SPI reads, writes
// (R11) Firmware copies images before engine start
// (R12) Refused erase completes, flash untouched
module fbm_guard #(
   parameter int CE_PAGE_W = fbm_pkg::FBM_CE_PAGE_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Bank select register in I/O space
   input wire logic bank_wr,
   input wire logic [1:0] bank_wdata,
   output logic [1:0] upper_bank_select,
   // Mode and engine placement
   input wire logic spi_flash_mode,
   input wire logic [CE_PAGE_W-1:0] engine_code_page,
   // SPI single-byte transaction
   input wire logic spi_sb_valid,
   input wire logic [1:0] spi_cmd,
   // Processor fetch
   input wire logic cpu_req,
   input wire logic [15:0] cpu_addr,
   output logic cpu_gnt,
   // Compute engine fetch
   input wire logic ce_req,
   input wire logic [11:0] ce_word,
   output logic ce_gnt,
   // SPI flash access
   input wire logic spi_req,
   input wire logic spi_wr,
   input wire logic [15:0] spi_addr,
   input wire logic [7:0] spi_wdata,
   output logic spi_gnt,
   // Page erase request
   input wire logic erase_req,
   output logic erase_done,
   output logic erase_refused,
   // Flash port
   output logic [16:0] flash_addr,
   output logic flash_rd,
   output logic flash_wr,
   output logic [7:0] flash_wdata,
   output logic flash_erase
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (CE_PAGE_W != fbm_pkg::FBM_CE_PAGE_W) begin : g_bad_page_w
      $error("engine page width must be seven bits");
   end

   // ************************************************************
   // State and translation
   // ************************************************************
   fbm_pkg::fbm_state_t st_reg;
   fbm_pkg::fbm_state_t st_next;
   logic [16:0] cpu_phys;
   logic [16:0] spi_phys;
   logic [16:0] ers_phys;
   logic [16:0] ce_phys;
   logic [16:0] ce_base;
   logic [6:0] ers_page;
   logic ers_blocked;

   // Processor fetch mapping
   fbm_xlate u_cpu_xlate (
      .prog_addr(cpu_addr),
      .bank(st_reg.bank),
      .phys_addr(cpu_phys)
   );

   // SPI uses the same window so all 128 KB stay reachable
   fbm_xlate u_spi_xlate (
      .prog_addr(spi_addr),
      .bank(st_reg.bank),
      .phys_addr(spi_phys)
   );

   // (R6) Pointer through bank
   fbm_xlate u_ers_xlate (
      .prog_addr({st_reg.pgptr, 9'h000}),
      .bank(st_reg.bank),
      .phys_addr(ers_phys)
   );

   // (R2) Low ten bits zero
   // (R3) Page forms start
   // (R7) No bank applied
   assign ce_base = {engine_code_page, 10'h000};

   // (R1) Twelve-bit word index
   assign ce_phys = ce_base + {4'h0, ce_word, 1'b0};

   // ************************************************************
   // Erase protection
   // ************************************************************

   // (R8) Page 0 or engine pages
   // Everything from the engine start to the top is covered, so code
   // stored above the engine program is protected as well.
   assign ers_page = ers_phys[16:10];
   assign ers_blocked = st_reg.lock &&
      (ers_page == fbm_pkg::FBM_PAGE_ZERO || ers_page >= engine_code_page);

   // ************************************************************
   // Flash port arbitration
   // ************************************************************

   // Erase first, then SPI, engine, processor
   assign spi_gnt = spi_req && !erase_req;
   assign ce_gnt = ce_req && !erase_req && !spi_req;
   assign cpu_gnt = cpu_req && !erase_req && !spi_req && !ce_req;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.frd = 1'b0;
      st_next.fwr = 1'b0;
      st_next.fers = 1'b0;
      st_next.edone = 1'b0;

      // Register writes
      if (sfr_wr && sfr_addr == fbm_pkg::FBM_SFR_PGPTR) begin
         st_next.pgptr = sfr_wdata[7:1];
      end
      if (sfr_wr && sfr_addr == fbm_pkg::FBM_SFR_LOCK) begin
         st_next.lock = sfr_wdata[fbm_pkg::FBM_LOCK_BIT];
      end
      if (bank_wr) begin
         st_next.bank = bank_wdata;
      end
      // (R9) SPI overwrites bank
      // Placed last so the SPI load wins over a same-cycle write.
      if (spi_flash_mode && spi_sb_valid) begin
         st_next.bank = spi_cmd;
      end

      // Register reads, unmapped addresses read zero
      if (sfr_rd) begin
         st_next.sfr_rdata = 8'h00;
         if (sfr_addr == fbm_pkg::FBM_SFR_PGPTR) begin
            st_next.sfr_rdata = {st_reg.pgptr, 1'b0};
         end
         if (sfr_addr == fbm_pkg::FBM_SFR_LOCK) begin
            st_next.sfr_rdata[fbm_pkg::FBM_LOCK_BIT] = st_reg.lock;
         end
      end

      // Flash operations
      if (erase_req) begin
         // (R12) Refused erase still completes
         st_next.edone = 1'b1;
         st_next.erefused = ers_blocked;
         st_next.fers = !ers_blocked;
         st_next.faddr = {ers_page, 10'h000};
      end else if (spi_gnt) begin
         // (R10) SPI may write
         st_next.faddr = spi_phys;
         st_next.frd = !spi_wr;
         st_next.fwr = spi_wr;
         st_next.fwdata = spi_wdata;
      end else if (ce_gnt) begin
         // (R10) Engine read only
         st_next.faddr = ce_phys;
         st_next.frd = 1'b1;
      end else if (cpu_gnt) begin
         // (R10) Processor read only
         st_next.faddr = cpu_phys;
         st_next.frd = 1'b1;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.bank <= fbm_pkg::FBM_BANK_RST;
         st_reg.pgptr <= fbm_pkg::FBM_PGPTR_RST;
         st_reg.lock <= fbm_pkg::FBM_LOCK_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign sfr_rdata = st_reg.sfr_rdata;
   assign upper_bank_select = st_reg.bank;
   assign flash_addr = st_reg.faddr;
   assign flash_rd = st_reg.frd;
   assign flash_wr = st_reg.fwr;
   assign flash_wdata = st_reg.fwdata;
   assign flash_erase = st_reg.fers;
   assign erase_done = st_reg.edone;
   assign erase_refused = st_reg.erefused;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence seq_lock_set;
      sfr_wr && sfr_addr == fbm_pkg::FBM_SFR_LOCK && sfr_wdata[6];
   endsequence

   sequence seq_ptr_zero;
      sfr_wr && sfr_addr == fbm_pkg::FBM_SFR_PGPTR && sfr_wdata == 8'h00;
   endsequence

   sequence seq_erase_now;
      erase_req && !spi_sb_valid;
   endsequence

   sequence seq_ptr_write;
      sfr_wr && sfr_addr == fbm_pkg::FBM_SFR_PGPTR;
   endsequence

   sequence seq_ptr_read;
      sfr_rd && !sfr_wr && sfr_addr == fbm_pkg::FBM_SFR_PGPTR;
   endsequence

   // Bank load from SPI
   AST_BANK_SPI: assert property ( // (R9)
      spi_flash_mode && spi_sb_valid |=> upper_bank_select == $past(spi_cmd))
      else $error("bank select not loaded from SPI command");

   // Lower window never banked
   AST_LOWER_FIXED: assert property ( // (R4)
      cpu_gnt && !cpu_addr[15] |=> flash_rd && flash_addr == {1'b0, $past(cpu_addr)})
      else $error("lower window fetch translated");

   // Upper window base follows the bank
   AST_UPPER_MAP: assert property ( // (R5)
      cpu_gnt && cpu_addr[15] |=> flash_addr[16:15] == $past(st_reg.bank) &&
         flash_addr[14:0] == $past(cpu_addr[14:0]))
      else $error("upper window base wrong");

   // Engine fetch ignores the bank, offset within 8 KB
   AST_CE_DIRECT: assert property ( // (R7)
      ce_gnt |=> flash_rd &&
         flash_addr == {$past(engine_code_page), 10'h000} + {4'h0, $past(ce_word), 1'b0})
      else $error("engine fetch address wrong");

   // Only an SPI grant produces a flash write
   AST_READ_ONLY: assert property ( // (R10)
      flash_wr |-> $past(spi_gnt) && $past(spi_wr))
      else $error("flash write without SPI write grant");

   // Page 0 erase refused under lock
   AST_ERASE_BLOCK: assert property ( // (R8)
      seq_ptr_zero ##1 !sfr_wr ##1 seq_lock_set ##1 !sfr_wr ##1 seq_erase_now |=>
         erase_done && erase_refused && !flash_erase)
      else $error("locked page 0 erased");

   // Unlocked erase goes out with the translated page
   AST_ERASE_GO: assert property ( // (R6)
      erase_req && !st_reg.lock |=> flash_erase && erase_done && !erase_refused &&
         flash_addr == {$past(ers_phys[16:10]), 10'h000})
      else $error("unlocked erase not issued");

   // Refused erase stays quiet; only a fresh erase may strobe next
   AST_REFUSED_QUIET: assert property ( // (R12)
      erase_req && ers_blocked |=> erase_done && !flash_erase && !flash_wr ##1
         (!flash_erase || $past(erase_req)))
      else $error("refused erase altered flash");

   // Pointer read back with bit 0 clear
   AST_PTR_READBACK: assert property ( // (R6)
      seq_ptr_write ##1 !sfr_wr ##1 seq_ptr_read |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'hfe))
      else $error("page pointer readback wrong");

endmodule : fbm_guard

`default_nettype wire

// [dv/fbm_req_model.sv]
/*
 Requester model for the processor, engine or SPI host side of the guard.
 Assumes go pulses for one falling edge and gnt is combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module fbm_req_model #(
   parameter int W = 16
) (
   // Clock and command from the bench
   input wire logic clk,
   input wire logic go,
   input wire logic [W-1:0] addr_in,
   // Handshake toward the guard
   input wire logic gnt,
   output logic req,
   output logic [W-1:0] addr,
   output logic taken
);
   initial begin
      req = 1'b0;
      addr = '0;
      taken = 1'b0;
   end
   // Grant is sampled on the rising edge only
   always @(posedge clk) begin
      taken <= req && gnt;
   end
   always @(negedge clk) begin
      if (go) begin
         req <= 1'b1;
         addr <= addr_in;
      end else if (taken) begin
         req <= 1'b0;
         addr <= ~addr; // Released bus shows junk, never the old value
      end
   end
endmodule : fbm_req_model
`default_nettype wire

// [dv/fbm_guard_tb.sv]
/*
 Self-checking bench for the flash bank map and erase guard.
 Assumes the guard answers one cycle after each taken request.
*/
`timescale 1ns/1ps
`default_nettype none

module fbm_guard_tb;
   logic clk, rst_n, sfr_wr, sfr_rd, bank_wr, spi_flash_mode, spi_sb_valid, spi_wr, erase_req;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, spi_wdata, flash_wdata;
   logic [1:0] bank_wdata, spi_cmd, upper_bank_select, cur;
   logic [6:0] engine_code_page;
   logic cpu_req, ce_req, spi_req, cpu_gnt, ce_gnt, spi_gnt;
   logic erase_done, erase_refused, flash_rd, flash_wr, flash_erase;
   logic [15:0] cpu_addr, spi_addr, a_cpu, a_spi;
   logic [11:0] ce_word, a_ce;
   logic [16:0] flash_addr;
   logic [2:0] go, tk;
   logic [31:0] r;
   int n_errors, num_checks, seed;

   fbm_guard i_fbm_guard (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bank_wr(bank_wr),
      .bank_wdata(bank_wdata), .upper_bank_select(upper_bank_select),
      .spi_flash_mode(spi_flash_mode), .engine_code_page(engine_code_page),
      .spi_sb_valid(spi_sb_valid), .spi_cmd(spi_cmd), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
      .cpu_gnt(cpu_gnt), .ce_req(ce_req), .ce_word(ce_word), .ce_gnt(ce_gnt),
      .spi_req(spi_req), .spi_wr(spi_wr), .spi_addr(spi_addr), .spi_wdata(spi_wdata),
      .spi_gnt(spi_gnt), .erase_req(erase_req), .erase_done(erase_done),
      .erase_refused(erase_refused), .flash_addr(flash_addr), .flash_rd(flash_rd),
      .flash_wr(flash_wr), .flash_wdata(flash_wdata), .flash_erase(flash_erase));
   // One requester model per flash client
   fbm_req_model #(.W(16)) i_fbm_req_model_cpu (.clk(clk), .go(go[0]), .addr_in(a_cpu),
      .gnt(cpu_gnt), .req(cpu_req), .addr(cpu_addr), .taken(tk[0]));
   fbm_req_model #(.W(12)) i_fbm_req_model_ce (.clk(clk), .go(go[1]), .addr_in(a_ce),
      .gnt(ce_gnt), .req(ce_req), .addr(ce_word), .taken(tk[1]));
   fbm_req_model #(.W(16)) i_fbm_req_model_spi (.clk(clk), .go(go[2]), .addr_in(a_spi),
      .gnt(spi_gnt), .req(spi_req), .addr(spi_addr), .taken(tk[2]));

   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Program address to flash, worked out independently
   function automatic logic [16:0] xl(input logic [15:0] a, input logic [1:0] b);
      return a[15] ? {b, a[14:0]} : {2'h0, a[14:0]};
   endfunction : xl

   task automatic chk(input logic [16:0] s, input logic [16:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(negedge clk);
      sfr_wr <= 1'b0;
   endtask : sw

   task automatic srd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(negedge clk);
      sfr_rd <= 1'b0;
      chk(sfr_rdata, e);
   endtask : srd

   // Load bank select by port or by SPI single byte
   task automatic bank(input logic [1:0] b, input logic m);
      @(negedge clk);
      if (m) begin
         spi_cmd <= b;
         spi_sb_valid <= 1'b1;
      end else begin
         bank_wdata <= b;
         bank_wr <= 1'b1;
      end
      @(negedge clk);
      spi_sb_valid <= 1'b0;
      bank_wr <= 1'b0;
      if (!m || spi_flash_mode)
         cur = b;
      chk(upper_bank_select, cur);
   endtask : bank

   // Client k: 0 processor, 1 engine, 2 SPI
   task automatic acc(input int k, input logic w, input logic [15:0] a, input logic [16:0] e);
      @(negedge clk);
      a_cpu <= a;
      a_spi <= a;
      a_ce <= a[11:0];
      spi_wr <= w;
      go[k] <= 1'b1;
      @(negedge clk);
      go[k] <= 1'b0;
      for (int n = 0; n < 20 && tk[k] !== 1'b1; n++) @(negedge clk);
      chk(flash_rd, !w);
      chk(flash_wr, w);
      chk(flash_addr, e);
      if (w)
         chk(flash_wdata, spi_wdata);
   endtask : acc

   task automatic erase(input logic [6:0] p, input logic l);
      logic [16:0] ph;
      logic rf;
      sw(8'hb7, {p, 1'b0});
      sw(8'hb2, {1'b0, l, 6'h0});
      ph = xl({p, 9'h0}, cur);
      rf = l && (ph[16:10] == 7'h0 || ph[16:10] >= engine_code_page);
      @(negedge clk);
      erase_req <= 1'b1;
      @(negedge clk);
      erase_req <= 1'b0;
      chk(erase_done, 1'b1);
      chk(flash_erase, !rf);
      chk(erase_refused, rf);
      if (!rf)
         chk(flash_addr, {ph[16:10], 10'h0});
   endtask : erase

   // Main sequence: reset, corners, then random traffic
   initial begin
      seed = 82206;
      {rst_n, sfr_wr, sfr_rd, bank_wr, spi_flash_mode, spi_sb_valid, spi_wr, erase_req} = '0;
      {sfr_addr, sfr_wdata, spi_wdata, bank_wdata, spi_cmd, go, cur} = '0;
      {a_cpu, a_spi, a_ce} = '0;
      engine_code_page = 7'h40;
      n_errors = 0;
      num_checks = 0;
      repeat (16) @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(upper_bank_select, 2'h0);
      chk(erase_refused, 1'b0);
      srd(8'hb7, 8'h00);
      sw(8'hb7, 8'h35);
      srd(8'hb7, 8'h34);
      sw(8'hb2, 8'hff);
      srd(8'hb2, 8'h40);
      srd(8'h80, 8'h00);
      spi_flash_mode <= 1'b1;
      @(negedge clk);
      bank_wdata <= 2'h1;
      bank_wr <= 1'b1;
      spi_cmd <= 2'h2;
      spi_sb_valid <= 1'b1;
      @(negedge clk);
      bank_wr <= 1'b0;
      spi_sb_valid <= 1'b0;
      cur = 2'h2;
      chk(upper_bank_select, cur);
      for (int b = 0; b < 4; b++) begin
         bank(b[1:0], b[0]);
         acc(0, 1'b0, 16'h7fff, 17'h07fff);
         acc(0, 1'b0, 16'h8004, xl(16'h8004, cur));
         acc(2, 1'b1, 16'hffff, xl(16'hffff, cur));
         acc(1, 1'b0, 16'h0fff, 17'h11ffe);
      end
      @(negedge clk);
      a_cpu <= 16'h1234;
      a_spi <= 16'h0abc;
      spi_wr <= 1'b0;
      go <= 3'h5;
      @(negedge clk);
      go <= 3'h0;
      @(negedge clk);
      chk(tk, 3'h4);
      chk(flash_addr, 17'h00abc);
      @(negedge clk);
      chk(tk, 3'h1);
      chk(flash_addr, 17'h01234);
      spi_flash_mode <= 1'b0;
      bank(~cur, 1'b1);
      bank(2'h0, 1'b0);
      erase(7'h40, 1'b1);
      erase(7'h00, 1'b1);
      erase(7'h01, 1'b1);
      erase(7'h02, 1'b1);
      erase(7'h7e, 1'b1);
      erase(7'h40, 1'b0);
      bank(2'h2, 1'b0);
      erase(7'h40, 1'b1);
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         spi_flash_mode <= r[3];
         spi_wdata <= r[31:24];
         bank(r[1:0], r[2]);
         acc(0, 1'b0, r[31:16], xl(r[31:16], cur));
         acc(2, r[4], r[15:0], xl(r[15:0], cur));
         engine_code_page <= r[22:16];
         acc(1, 1'b0, r[15:0], {r[22:16], 10'h0} + {4'h0, r[11:0], 1'b0});
         erase(r[14:8], r[5]);
      end
      test_done;
   end

   // Watchdog, far beyond the expected run
   initial begin
      #200000;
      n_errors++;
      test_done;
   end
endmodule : fbm_guard_tb
`default_nettype wire
